// File: hw/mcs_pkg.sv
package mcs_pkg;
   // Cycle types
   typedef enum logic [3:0] {
      MCS_CT_FETCH = 4'h0,
      MCS_CT_MRD = 4'h1,
      MCS_CT_MWR = 4'h2,
      MCS_CT_SRD = 4'h3,
      MCS_CT_SWR = 4'h4,
      MCS_CT_INP = 4'h5,
      MCS_CT_OUT = 4'h6,
      MCS_CT_IACK = 4'h7,
      MCS_CT_HALT = 4'h8,
      MCS_CT_IACKH = 4'h9,
      MCS_CT_NONE = 4'hA
   } mcs_ctype_type;
   // Address sources
   typedef enum logic [2:0] {
      MCS_AS_PC = 3'h0,
      MCS_AS_HL = 3'h1,
      MCS_AS_BC = 3'h2,
      MCS_AS_DE = 3'h3,
      MCS_AS_SP = 3'h4,
      MCS_AS_BB = 3'h5,
      MCS_AS_AB = 3'h6
   } mcs_asrc_type;
   // Status words
   localparam logic [7:0] MCS_ST_FETCH = 8'hA2;
   localparam logic [7:0] MCS_ST_MRD = 8'h82;
   localparam logic [7:0] MCS_ST_MWR = 8'h00;
   localparam logic [7:0] MCS_ST_SRD = 8'h86;
   localparam logic [7:0] MCS_ST_SWR = 8'h04;
   localparam logic [7:0] MCS_ST_INP = 8'h42;
   localparam logic [7:0] MCS_ST_OUT = 8'h10;
   localparam logic [7:0] MCS_ST_IACK = 8'h23;
   localparam logic [7:0] MCS_ST_HALT = 8'h8A;
   localparam logic [7:0] MCS_ST_IACKH = 8'h2B;
   localparam logic [7:0] MCS_ST_NONE = 8'h00;
   // Status bit positions
   localparam int MCS_B_INTA = 0;
   localparam int MCS_B_WO = 1;
   localparam int MCS_B_STACK = 2;
   localparam int MCS_B_HALT_ACK_STATUS = 3;
   localparam int MCS_B_OUT = 4;
   localparam int MCS_B_M1 = 5;
   localparam int MCS_B_INP = 6;
   localparam int MCS_B_MEM_READ_STATUS = 7;
   // Cycle and state limits
   localparam logic [2:0] MCS_MAX_CYC = 3'h5;
   localparam logic [2:0] MCS_MIN_ST = 3'h3;
   localparam logic [2:0] MCS_MAX_ST = 3'h5;
   localparam logic [2:0] MCS_FETCH_ST = 3'h4;
   localparam logic [2:0] MCS_RESET_M = 3'h1;
   localparam logic [2:0] MCS_RESET_T = 3'h1;
endpackage : mcs_pkg

// File: hw/mcs_cycle_plan.sv
`timescale 1ns/100ps
`default_nettype none
// Decodes one opcode and the cycle index into the plan of that cycle.
module mcs_cycle_plan (
   input wire logic [7:0] opcode_i,
   input wire logic [2:0] mcyc_i,
   input wire logic cond_true_i,
   output logic [2:0] ncyc_o,
   output logic [2:0] nstate_o,
   output mcs_pkg::mcs_ctype_type ctype_o,
   output mcs_pkg::mcs_asrc_type asrc_o
);
   logic [2:0] n;
   logic [2:0] f;
   mcs_pkg::mcs_ctype_type t;
   mcs_pkg::mcs_asrc_type a;
   logic [7:0] op;
   assign op = opcode_i;
   always_comb begin
      n = 3'h1;
      f = mcs_pkg::MCS_FETCH_ST;
      t = mcs_pkg::MCS_CT_MRD;
      a = mcs_pkg::MCS_AS_PC;
      if (op == 8'hC3 || op[7:6] == 2'h3 && op[2:0] == 3'h2 ||
          op[7:6] == 2'h0 && op[3:0] == 4'h1) begin
         n = 3'h3;
      end else if (op == 8'hCD || op[7:6] == 2'h3 && op[2:0] == 3'h4) begin
         n = (op == 8'hCD || cond_true_i) ? 3'h5 : 3'h3;
         f = 3'h5;
      end else if (op[7:6] == 2'h3 && op[2:0] == 3'h0) begin
         n = cond_true_i ? 3'h3 : 3'h1;
         f = 3'h5;
      end else if (op == 8'hC9 || op[7:6] == 2'h3 && op[3:0] == 4'h1) begin
         n = 3'h3;
      end else if (op[7:6] == 2'h3 && op[3:0] == 4'h5 ||
                   op[7:6] == 2'h3 && op[2:0] == 3'h7) begin
         n = 3'h3;
         f = 3'h5;
      end else if (op == 8'hE3) begin
         n = 3'h5;
      end else if (op[7:6] == 2'h0 && op[3:0] == 4'h9) begin
         n = 3'h3;
      end else if (op == 8'h3A || op == 8'h32) begin
         n = 3'h4;
      end else if (op == 8'h2A || op == 8'h22) begin
         n = 3'h5;
      end else if (op == 8'hDB || op == 8'hD3 || op == 8'h34 ||
                   op == 8'h35 || op == 8'h36) begin
         n = 3'h3;
      end else if (op == 8'h76) begin
         n = 3'h2;
      end else if (op[7:6] == 2'h1 && (op[2:0] == 3'h6 || op[5:3] == 3'h6) ||
                   op[7:6] == 2'h2 && op[2:0] == 3'h6 ||
                   op[7:6] == 2'h3 && op[2:0] == 3'h6 ||
                   op[7:6] == 2'h0 && op[2:0] == 3'h6 ||
                   op[7:6] == 2'h0 && op[2:0] == 3'h2 && !op[5]) begin
         n = 3'h2;
      end else if (op == 8'hE9 || op == 8'hF9 ||
                   op[7:6] == 2'h1 && op[2:0] != 3'h6 ||
                   op[7:6] == 2'h0 && op[2:1] == 2'h2 ||
                   op[7:6] == 2'h0 && op[2:0] == 3'h3) begin
         f = 3'h5;
      end
      // rotates and the one-cycle ops not set to five above stay four
      nstate_o = (mcyc_i == 3'h1) ? f : mcs_pkg::MCS_MIN_ST;
      if (op == 8'hE3 && mcyc_i == 3'h5) begin
         nstate_o = mcs_pkg::MCS_MAX_ST;
      end
      if (mcyc_i == 3'h1) begin
         t = mcs_pkg::MCS_CT_FETCH;
      end else if (op == 8'h76) begin
         t = mcs_pkg::MCS_CT_HALT;
      end else if (op[7:6] == 2'h0 && op[3:0] == 4'h9) begin
         t = mcs_pkg::MCS_CT_NONE;
      end else if (op == 8'hE3) begin
         t = (mcyc_i < 3'h4) ? mcs_pkg::MCS_CT_SRD : mcs_pkg::MCS_CT_SWR;
         a = mcs_pkg::MCS_AS_SP;
      end else if (op == 8'hCD || op[7:6] == 2'h3 && op[2:0] == 3'h4) begin
         t = (mcyc_i < 3'h4) ? mcs_pkg::MCS_CT_MRD : mcs_pkg::MCS_CT_SWR;
         a = (mcyc_i < 3'h4) ? mcs_pkg::MCS_AS_PC : mcs_pkg::MCS_AS_SP;
      end else if (op[7:6] == 2'h3 && (op[2:0] == 3'h0 || op[3:0] == 4'h1 ||
                   op == 8'hC9)) begin
         t = mcs_pkg::MCS_CT_SRD;
         a = mcs_pkg::MCS_AS_SP;
      end else if (op[7:6] == 2'h3 && (op[3:0] == 4'h5 || op[2:0] == 3'h7)) begin
         t = mcs_pkg::MCS_CT_SWR;
         a = mcs_pkg::MCS_AS_SP;
      end else if (mcyc_i > 3'h3 || (op == 8'hDB || op == 8'hD3) &&
                   mcyc_i == 3'h3) begin
         a = (op == 8'hDB || op == 8'hD3) ? mcs_pkg::MCS_AS_AB :
             mcs_pkg::MCS_AS_BB;
         if (op == 8'hDB) begin
            t = mcs_pkg::MCS_CT_INP;
         end else if (op == 8'hD3) begin
            t = mcs_pkg::MCS_CT_OUT;
         end else if (op == 8'h32 || op == 8'h22) begin
            t = mcs_pkg::MCS_CT_MWR;
         end
      end else if ((op == 8'h34 || op == 8'h35) && mcyc_i == 3'h3 ||
                   op == 8'h36 && mcyc_i == 3'h3 ||
                   op[7:3] == 5'h0E && mcyc_i == 3'h2) begin
         t = mcs_pkg::MCS_CT_MWR;
         a = mcs_pkg::MCS_AS_HL;
      end else if (op == 8'h34 || op == 8'h35 || op[7:6] != 2'h0 &&
                   op[2:0] == 3'h6 && op[7:6] != 2'h3) begin
         a = mcs_pkg::MCS_AS_HL;
      end else if (op[7:6] == 2'h0 && op[2:0] == 3'h2 && !op[5]) begin
         t = op[3] ? mcs_pkg::MCS_CT_MRD : mcs_pkg::MCS_CT_MWR;
         a = op[4] ? mcs_pkg::MCS_AS_DE : mcs_pkg::MCS_AS_BC;
      end
   end
   assign ncyc_o = n;
   assign ctype_o = t;
   assign asrc_o = a;
endmodule // mcs_cycle_plan
`default_nettype wire

// File: hw/mcs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Steps machine cycles and states; presents status in the first state.
module mcs_sequencer (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] opcode_i,
   input wire logic opcode_valid_i,
   input wire logic int_pending_i,
   input wire logic flag_sign_i,
   input wire logic flag_zero_i,
   input wire logic flag_parity_i,
   input wire logic flag_carry_i,
   input wire logic [7:0] acc_i,
   output logic sync_o,
   output logic [7:0] status_o,
   output logic status_oe_o,
   output logic bus_in_strobe_o,
   output logic write_strobe_o,
   output logic [2:0] mcycle_o,
   output logic [2:0] tstate_o,
   output logic [2:0] addr_src_o,
   output logic branch_taken_o,
   output logic halted_o,
   output logic [7:0] rot_acc_o,
   output logic rot_carry_o
);
   logic [2:0] m_r;
   logic [2:0] t_r;
   logic [7:0] op_r;
   logic halt_r;
   logic iack_r;
   logic [7:0] status_r;
   logic [7:0] rot_r;
   logic rotc_r;
   logic [2:0] ncyc;
   logic [2:0] nst;
   mcs_pkg::mcs_ctype_type ct;
   mcs_pkg::mcs_asrc_type as;
   logic cond;
   logic [7:0] cur_op;
   logic cyc_end;
   logic inst_end;
   logic [7:0] st_word;
   logic rd_cyc;
   logic wr_cyc;
   assign cond = (op_r[5:4] == 2'h0) ? (flag_zero_i == op_r[3]) :
                 (op_r[5:4] == 2'h1) ? (flag_carry_i == op_r[3]) :
                 (op_r[5:4] == 2'h2) ? (flag_parity_i == op_r[3]) :
                 (flag_sign_i == op_r[3]);
   assign cur_op = (m_r == 3'h1 && t_r == 3'h3) ? opcode_i : op_r;
   mcs_cycle_plan u_plan (
      .opcode_i(cur_op),
      .mcyc_i(m_r),
      .cond_true_i(cond),
      .ncyc_o(ncyc),
      .nstate_o(nst),
      .ctype_o(ct),
      .asrc_o(as)
   );
   assign cyc_end = (t_r >= nst) && (m_r != 3'h1 || t_r > 3'h2);
   assign inst_end = cyc_end && m_r >= ncyc;
   assign st_word =
      (m_r == 3'h1 && iack_r && halt_r) ? mcs_pkg::MCS_ST_IACKH :
      (m_r == 3'h1 && iack_r) ? mcs_pkg::MCS_ST_IACK :
      (ct == mcs_pkg::MCS_CT_FETCH) ? mcs_pkg::MCS_ST_FETCH :
      (ct == mcs_pkg::MCS_CT_MRD) ? mcs_pkg::MCS_ST_MRD :
      (ct == mcs_pkg::MCS_CT_MWR) ? mcs_pkg::MCS_ST_MWR :
      (ct == mcs_pkg::MCS_CT_SRD) ? mcs_pkg::MCS_ST_SRD :
      (ct == mcs_pkg::MCS_CT_SWR) ? mcs_pkg::MCS_ST_SWR :
      (ct == mcs_pkg::MCS_CT_INP) ? mcs_pkg::MCS_ST_INP :
      (ct == mcs_pkg::MCS_CT_OUT) ? mcs_pkg::MCS_ST_OUT :
      (ct == mcs_pkg::MCS_CT_HALT) ? mcs_pkg::MCS_ST_HALT :
      mcs_pkg::MCS_ST_NONE;
   assign rd_cyc = st_word[mcs_pkg::MCS_B_WO] && ct != mcs_pkg::MCS_CT_HALT;
   assign wr_cyc = !st_word[mcs_pkg::MCS_B_WO] && ct != mcs_pkg::MCS_CT_NONE;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         m_r <= mcs_pkg::MCS_RESET_M;
         t_r <= mcs_pkg::MCS_RESET_T;
         op_r <= 8'h00;
         halt_r <= 1'b0;
         iack_r <= 1'b0;
         status_r <= 8'h00;
      end else begin
         if (t_r == 3'h1) begin
            status_r <= st_word;
         end
         if (m_r == 3'h1 && t_r == 3'h3) begin
            op_r <= opcode_i;
         end
         if (halt_r && !iack_r) begin
            // hold in halt; wake one clock after a request
            t_r <= 3'h1;
            iack_r <= int_pending_i;
         end else if (inst_end) begin
            m_r <= 3'h1;
            t_r <= 3'h1;
            halt_r <= (op_r == 8'h76) && !iack_r;
            iack_r <= int_pending_i;
         end else if (cyc_end) begin
            m_r <= m_r + 3'h1;
            t_r <= 3'h1;
         end else if (!(m_r == 3'h1 && t_r == 3'h2 && !opcode_valid_i)) begin
            t_r <= t_r + 3'h1;
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rot_r <= 8'h00;
         rotc_r <= 1'b0;
      end else if (inst_end && op_r[7:5] == 3'h0 && op_r[2:0] == 3'h7) begin
         case (op_r[4:3])
            2'h0: {rotc_r, rot_r} <= {acc_i[7], acc_i[6:0], acc_i[7]};
            2'h1: {rotc_r, rot_r} <= {acc_i[0], acc_i[0], acc_i[7:1]};
            2'h2: {rotc_r, rot_r} <= {acc_i, flag_carry_i};
            default: {rot_r, rotc_r} <= {flag_carry_i, acc_i};
         endcase
      end
   end
   assign sync_o = (t_r == 3'h1) && !(halt_r && !iack_r);
   assign status_o = (t_r == 3'h1) ? st_word : status_r;
   assign status_oe_o = sync_o;
   assign bus_in_strobe_o = rd_cyc && t_r == 3'h2;
   assign write_strobe_o = wr_cyc && t_r == 3'h3;
   assign mcycle_o = m_r;
   assign tstate_o = t_r;
   assign addr_src_o = as;
   assign branch_taken_o = inst_end && (op_r == 8'hC3 ||
                           op_r[7:6] == 2'h3 && op_r[2:0] == 3'h2 && cond);
   assign halted_o = halt_r;
   assign rot_acc_o = rot_r;
   assign rot_carry_o = rotc_r;
endmodule // mcs_sequencer
`default_nettype wire

// File: sim/mcs_seq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_seq_chk (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic sync_o,
   input wire logic [7:0] status_o,
   input wire logic status_oe_o,
   input wire logic bus_in_strobe_o,
   input wire logic write_strobe_o,
   input wire logic [2:0] mcycle_o,
   input wire logic [2:0] tstate_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   a_status_word_table: assert property (
      sync_o |-> status_o inside {8'hA2, 8'h82, 8'h00, 8'h86, 8'h04,
      8'h42, 8'h10, 8'h23, 8'h8A, 8'h2B})
      else $error("status word outside table");
   a_oe_with_sync: assert property (
      status_oe_o == sync_o) else $error("status enable not with sync");
   a_sync_first_state: assert property (
      sync_o |-> tstate_o == 3'h1) else $error("sync outside first state");
   a_fetch_first_cycle: assert property (
      sync_o && status_o[5] |-> mcycle_o == 3'h1)
      else $error("fetch status outside first cycle");
   a_count_range: assert property (
      tstate_o inside {[3'h1:3'h5]} && mcycle_o inside {[3'h1:3'h5]})
      else $error("cycle or state count out of range");
   a_cycle_min_states: assert property (
      sync_o |=> !sync_o [*2]) else $error("cycle shorter than three");
   a_fetch_min_states: assert property (
      sync_o && status_o[5] |=> !sync_o [*3])
      else $error("fetch shorter than four");
   a_read_strobe_t2: assert property (
      sync_o && status_o inside {8'hA2, 8'h82, 8'h86, 8'h42, 8'h23, 8'h2B}
      |=> bus_in_strobe_o && !write_strobe_o)
      else $error("read cycle without input strobe");
   a_write_strobe_t3: assert property (
      sync_o && status_o inside {8'h04, 8'h10} |-> ##2 write_strobe_o)
      else $error("write cycle without write strobe");
   a_strobe_states: assert property (
      (bus_in_strobe_o |-> tstate_o == 3'h2) and
      (write_strobe_o |-> tstate_o == 3'h3))
      else $error("strobe in wrong state");
endmodule // mcs_seq_chk
bind mcs_sequencer mcs_seq_chk mcs_seq_chk_i (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .sync_o(sync_o),
   .status_o(status_o), .status_oe_o(status_oe_o),
   .bus_in_strobe_o(bus_in_strobe_o), .write_strobe_o(write_strobe_o),
   .mcycle_o(mcycle_o), .tstate_o(tstate_o)
);
`default_nettype wire

// File: sim/mcs_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_far_side (
   input wire logic core_clk_i,
   input wire logic sync_i,
   input wire logic [7:0] status_i,
   input wire logic [2:0] tstate_i,
   input wire logic [7:0] op_i,
   output logic [7:0] opcode_o,
   output logic opcode_valid_o
);
   logic [7:0] st_r = 8'h00;
   logic [7:0] last_r = 8'h00;
   logic drive;
   always @(posedge core_clk_i) begin
      if (sync_i) begin
         st_r <= status_i;
      end
      last_r <= opcode_o;
   end
   assign drive = st_r[5] && (tstate_i == 3'h2 || tstate_i == 3'h3);
   assign opcode_o = !drive ? ~last_r : (st_r[0] ? 8'hFF : op_i);
   assign opcode_valid_o = drive;
endmodule // mcs_far_side
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] op = 8'h00;
   logic [7:0] acc = 8'h81;
   logic irq = 1'b0;
   logic zf = 1'b0;
   logic sf = 1'b0;
   logic pf = 1'b0;
   logic cf = 1'b0;
   logic [14:0] asq;
   logic [7:0] opcode, status, rot_acc;
   logic opv, sync, oe, rd_stb, wr_stb, bt, halted, rot_c;
   logic [2:0] mcyc, tst, asrc;
   logic [7:0] rop [4] = '{8'h07, 8'h0F, 8'h17, 8'h1F};
   logic [7:0] rres [4] = '{8'h03, 8'hC0, 8'h02, 8'h40};
   int n_errors = 0;
   int checks_done = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   mcs_sequencer mcs_sequencer_i (.core_clk_i(core_clk_i),
      .nrst_i(nrst_i), .opcode_i(opcode), .opcode_valid_i(opv),
      .int_pending_i(irq), .flag_sign_i(sf), .flag_zero_i(zf),
      .flag_parity_i(pf), .flag_carry_i(cf), .acc_i(acc),
      .sync_o(sync), .status_o(status), .status_oe_o(oe),
      .bus_in_strobe_o(rd_stb), .write_strobe_o(wr_stb), .mcycle_o(mcyc),
      .tstate_o(tst), .addr_src_o(asrc), .branch_taken_o(bt),
      .halted_o(halted), .rot_acc_o(rot_acc), .rot_carry_o(rot_c));
   mcs_far_side mcs_far_side_i (.core_clk_i(core_clk_i), .sync_i(sync),
      .status_i(status), .tstate_i(tst), .op_i(op), .opcode_o(opcode),
      .opcode_valid_o(opv));
   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Runs one instruction from its fetch to the next fetch
   task automatic run_op(input logic [7:0] o, input logic z,
      input logic i, input logic [7:0] clks, input logic [39:0] sw,
      input logic b);
      logic [39:0] got;
      logic t;
      int c;
      t = 1'b0;
      c = 0;
      while (!(sync === 1'b1 && status[5] === 1'b1) && c < 300) begin
         @(negedge core_clk_i);
         c++;
      end
      op = o;
      zf = z;
      irq = i;
      got = {32'h0, status};
      asq = {12'h0, asrc};
      c = 0;
      do begin
         @(negedge core_clk_i);
         c++;
         t = t | bt;
         if (sync === 1'b1 && status[5] !== 1'b1) begin
            got = {got[31:0], status};
            asq = {asq[11:0], asrc};
         end
      end while (!(sync === 1'b1 && status[5] === 1'b1) && c < 300);
      check(got, sw);
      check({32'h0, c[7:0]}, {32'h0, clks});
      check({39'h0, t}, {39'h0, b});
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge core_clk_i);
      nrst_i = 1'b1;
      run_op(8'h00, 0, 0, 4, 40'hA2, 0);
      run_op(8'hC3, 0, 0, 10, 40'hA28282, 1);
      run_op(8'hCA, 0, 0, 10, 40'hA28282, 0);
      run_op(8'hCA, 1, 0, 10, 40'hA28282, 1);
      run_op(8'hE2, 0, 0, 10, 40'hA28282, 1);
      run_op(8'hF2, 0, 0, 10, 40'hA28282, 1);
      run_op(8'h09, 0, 0, 10, 40'hA20000, 0);
      run_op(8'h34, 0, 0, 10, 40'hA28200, 0);
      check({25'h0, asq}, 40'h009);
      run_op(8'h35, 0, 0, 10, 40'hA28200, 0);
      run_op(8'h3A, 0, 0, 13, 40'hA2828282, 0);
      check({25'h0, asq}, 40'h005);
      run_op(8'h32, 0, 0, 13, 40'hA2828200, 0);
      run_op(8'h2A, 0, 0, 16, 40'hA282828282, 0);
      run_op(8'h22, 0, 0, 16, 40'hA282820000, 0);
      run_op(8'hD3, 0, 0, 10, 40'hA28210, 0);
      check({25'h0, asq}, 40'h006);
      run_op(8'hDB, 0, 0, 10, 40'hA28242, 0);
      run_op(8'hE3, 0, 0, 18, 40'hA286860404, 0);
      check({25'h0, asq}, 40'h924);
      run_op(8'hE9, 0, 0, 5, 40'hA2, 0);
      run_op(8'hC4, 0, 0, 17, 40'hA282820404, 0);
      check({25'h0, asq}, 40'h024);
      run_op(8'hC4, 1, 0, 11, 40'hA28282, 0);
      run_op(8'hC0, 0, 0, 11, 40'hA28686, 0);
      run_op(8'hC0, 1, 0, 5, 40'hA2, 0);
      for (int k = 0; k < 4; k++) begin
         run_op(rop[k], 0, 0, 4, 40'hA2, 0);
         check({32'h0, rot_acc}, {32'h0, rres[k]});
         check({39'h0, rot_c}, 40'h1);
      end
      sf = 1'b1;
      pf = 1'b1;
      cf = 1'b1;
      run_op(8'hDA, 0, 0, 10, 40'hA28282, 1);
      run_op(8'hE2, 0, 0, 10, 40'hA28282, 0);
      run_op(8'hF2, 0, 0, 10, 40'hA28282, 0);
      run_op(8'h17, 0, 0, 4, 40'hA2, 0);
      check({32'h0, rot_acc}, 40'h03);
      run_op(8'h02, 0, 0, 7, 40'hA200, 0);
      check({25'h0, asq}, 40'h002);
      run_op(8'h1A, 0, 0, 7, 40'hA282, 0);
      check({25'h0, asq}, 40'h003);
      run_op(8'h00, 0, 1, 4, 40'hA2, 0);
      run_op(8'h00, 0, 0, 11, 40'h230404, 0);
      run_op(8'h76, 0, 1, 7, 40'hA28A, 0);
      check({39'h0, halted}, 40'h1);
      run_op(8'h00, 0, 0, 11, 40'h2B0404, 0);
      check({39'h0, halted}, 40'h0);
      op = 8'h76;
      repeat (20) @(negedge core_clk_i);
      check({39'h0, halted}, 40'h1);
      check({39'h0, sync}, 40'h0);
      irq = 1'b1;
      run_op(8'h00, 0, 0, 11, 40'h2B0404, 0);
      final_report();
   end
   // Bound well above the longest expected run
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      final_report();
   end
endmodule // testbench
`default_nettype wire
